// ### hw/fault_supervisor.sv
// Overview of operation
// - port overvoltage 16ms stops, 16ms resumes
// - divider mode: trip 24V, exit 22.74V
// - register mode: 112% trip, 106% exit
// - low port 32ms: overload, discharge off
// - overload level 1.76V or 80%
// - port below 1.76V 4ms: short
// - battery undervoltage: discharge off, switch on
// - undervoltage threshold 2.7-13.2V, default 3V
// - hysteresis 0.4-2V, default 0.4V
// - battery overvoltage 100us trip, 36ms recover
// - battery overvoltage 26V, recovery 24.63V
// - peak current cuts on-phase, four limits
// - boost sense scaled by resistance setting
// - charge input overvoltage 100us, 4ms exit
// - input limit reduces charge current
// - charge overvoltage: converter off, drain pulses
// - rail level one: immediate drain pulses
// - rail level two: converter, switch off
// - restart by flag clear or adapter
// - level two trips follow cell count
// - interrupt pin low while flag set
// - output voltage 3-22V, 10mV steps
`timescale 1ns/100ps
`default_nettype none
module fault_supervisor
   import power_path_pkg::*;
#(
   parameter int P_4MS  = CYC_4MS,
   parameter int P_16MS = CYC_16MS,
   parameter int P_32MS = CYC_32MS,
   parameter int P_36MS = CYC_36MS,
   parameter int P_64MS = CYC_64MS
) (
   // clocking
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // apb slave
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // comparator results, asynchronous
   input  wire power_path_pkg::cmp_t cmp_raw,
   // power path controls
   output logic                     dischg_on,
   output logic                     chg_on,
   output logic                     conv_on,
   output logic                     battery_path_switch_off,
   output logic                     drain_on,
   output logic                     pwm_cut,
   output logic                     in_limit_reduce,
   output logic [1:0]               peak_current_limit_setting,
   output logic [1:0]               switch_resistance_setting,
   output power_path_pkg::lvl_t     lvl,
   // open-drain interrupt pin
   output logic                     irq_o,
   output logic                     irq_oe
);
   import power_path_pkg::*;
   // ===========================================================
   // state
   typedef struct packed {
      cmp_t        s1, s2;
      logic        adp_d;
      logic        dis_en, chg_en, reg_mode;
      logic [1:0]  cells, ilim, rdson;
      logic [10:0] vout;
      logic [6:0]  uv;
      logic [4:0]  hys;
      logic [7:0]  inl;
      logic [11:0] chgt, sysmin;
      flags_t      flags, act;
      logic        rearm, conv_lock;
      logic [TW-1:0] dcnt;
      logic        dis_on, chg_on, conv_on, fet_off, drain_on;
      logic        pwm_cut, inl_red, irq_oe;
      lvl_t        lvl;
      logic [31:0] prdata;
      logic        pready, pslverr;
   } st_t;
   st_t r, n;
   logic [NTMR-1:0] tcond, tdone;
   logic [TW-1:0]   tlim [NTMR];

   function automatic logic [11:0] pct(input logic [11:0] v,
                                       input logic [6:0] p);
      logic [18:0] t;
      t = (19'(v) * 19'(p)) / 19'h64;
      return t[11:0];
   endfunction

   // ===========================================================
   // qualification timers
   // trip and exit conditions: port, battery, input, charge, rail
   assign tcond[TM_POV_IN]  = r.dis_en && r.s2.port_ov;
   assign tcond[TM_POV_OUT] = r.act.port_ov && r.s2.port_ov_exit;
   assign tcond[TM_OVL]     = r.dis_on && r.s2.port_ovl;
   assign tcond[TM_SHT]     = r.dis_on && r.s2.port_short;
   assign tcond[TM_UV_IN]   = r.dis_en && r.s2.bat_uv;
   assign tcond[TM_UV_OUT]  = r.act.bat_uv && r.s2.bat_uv_exit;
   assign tcond[TM_BOV_IN]  = r.dis_en && r.s2.bat_ov;
   assign tcond[TM_BOV_OUT] = r.act.bat_ov && r.s2.bat_ov_exit;
   assign tcond[TM_IOV_IN]  = r.chg_en && r.s2.in_ov;
   assign tcond[TM_IOV_OUT] = r.act.in_ov && r.s2.in_ov_exit;
   assign tcond[TM_COV_IN]  = r.chg_on && r.s2.chg_ov;
   assign tcond[TM_COV_OUT] = r.act.chg_ov && r.s2.chg_ov_exit;
   assign tcond[TM_OV2_IN]  = r.s2.sys_ov2;
   assign tcond[TM_OV2_OUT] = r.act.sys_ov && r.s2.sys_ov2_exit;

   assign tlim[TM_POV_IN]  = TW'(P_16MS);
   assign tlim[TM_POV_OUT] = TW'(P_16MS);
   assign tlim[TM_OVL]     = TW'(P_32MS);
   assign tlim[TM_SHT]     = TW'(P_4MS);
   assign tlim[TM_UV_IN]   = TW'(P_32MS);
   assign tlim[TM_UV_OUT]  = TW'(P_64MS);
   assign tlim[TM_BOV_IN]  = TW'(CYC_100US);
   assign tlim[TM_BOV_OUT] = TW'(P_36MS);
   assign tlim[TM_IOV_IN]  = TW'(CYC_100US);
   assign tlim[TM_IOV_OUT] = TW'(P_4MS);
   assign tlim[TM_COV_IN]  = TW'(P_16MS);
   assign tlim[TM_COV_OUT] = TW'(P_16MS);
   assign tlim[TM_OV2_IN]  = TW'(CYC_30US);
   assign tlim[TM_OV2_OUT] = TW'(P_4MS);

   genvar gi;
   generate
      for (gi = 0; gi < NTMR; gi++) begin : g_tmr
         qual_timer u_tmr (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .ce       (ce),
            .cond     (tcond[gi]),
            .limit    (tlim[gi]),
            .done     (tdone[gi])
         );
      end
   endgenerate

   // ===========================================================
   // next-state logic
   always_comb begin
      logic        setup, wr;
      logic        mapped;
      logic [31:0] rd;
      flags_t      clr;
      logic [11:0] vset, t12, hl;
      logic        dis_blk, dr_act, adp_rise;
      setup = 1'b0;
      wr = 1'b0;
      mapped = 1'b0;
      rd = '0;
      clr = '0;
      vset = '0;
      t12 = '0;
      hl = '0;
      dis_blk = 1'b0;
      dr_act = 1'b0;
      adp_rise = 1'b0;
      n = r;
      // two-stage pin synchroniser
      n.s1 = cmp_raw;
      n.s2 = r.s1;
      n.adp_d = r.s2.adapter;
      adp_rise = r.s2.adapter && !r.adp_d;

      // apb: answer one cycle after setup
      setup = psel && !penable && !r.pready;
      case (paddr)
         REG_CTRL: rd = {23'h0, r.rdson, r.ilim, r.cells, r.reg_mode,
                         r.chg_en, r.dis_en};
         REG_VOUT: rd = {21'h0, r.vout};
         REG_UV: rd = {19'h0, r.hys, 1'b0, r.uv};
         REG_INLIM: rd = {24'h0, r.inl};
         REG_CHGT: rd = {20'h0, r.chgt};
         REG_SYSMIN: rd = {20'h0, r.sysmin};
         REG_FLAGS: rd = {23'h0, r.flags};
         REG_STATE: rd = {16'h0, r.act, r.conv_lock, r.rearm, r.drain_on,
                          r.fet_off, r.conv_on, r.chg_on, r.dis_on};
         default: rd = '0;
      endcase
      mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
      n.pready = setup;
      n.pslverr = setup && !mapped;
      if (setup) begin
         n.prdata = mapped ? rd : '0;
      end
      wr = psel && penable && r.pready && pwrite && mapped;
      if (wr) begin
         case (paddr)
            REG_CTRL: begin
               {n.rdson, n.ilim, n.cells, n.reg_mode, n.chg_en,
                n.dis_en} = pwdata[8:0];
            end
            REG_VOUT: n.vout = pwdata[10:0];
            REG_UV: begin
               n.uv = pwdata[6:0];
               n.hys = pwdata[12:8];
            end
            REG_INLIM: n.inl = pwdata[7:0];
            REG_CHGT: n.chgt = pwdata[11:0];
            REG_SYSMIN: n.sysmin = pwdata[11:0];
            REG_FLAGS: clr = flags_t'(pwdata[8:0]);
            default: n.vout = r.vout;
         endcase
      end

      // ========================================================
      // fault states
      // trip after 16ms, exit after 16ms
      n.act.port_ov = r.act.port_ov ? !tdone[TM_POV_OUT]
                                    : tdone[TM_POV_IN];
      // overload and short stay until cleared
      n.act.overload = (r.act.overload && !clr.overload) || tdone[TM_OVL];
      n.act.short_c = (r.act.short_c && !clr.short_c) || tdone[TM_SHT];
      n.act.bat_uv = r.act.bat_uv ? !tdone[TM_UV_OUT] : tdone[TM_UV_IN];
      n.act.bat_ov = r.act.bat_ov ? !tdone[TM_BOV_OUT] : tdone[TM_BOV_IN];
      n.act.in_ov = r.act.in_ov ? !tdone[TM_IOV_OUT] : tdone[TM_IOV_IN];
      n.act.chg_ov = r.act.chg_ov ? !tdone[TM_COV_OUT] : tdone[TM_COV_IN];
      // level one has no qualification delay
      n.act.sys_ov1 = r.act.sys_ov1 ? !r.s2.sys_ov1_exit : r.s2.sys_ov1;
      n.act.sys_ov = r.act.sys_ov ? !tdone[TM_OV2_OUT] : tdone[TM_OV2_IN];
      // re-enable needed after overload or short
      if (tdone[TM_OVL] || tdone[TM_SHT]) begin
         n.rearm = 1'b1;
      end else if (!r.dis_en && !r.act.overload && !r.act.short_c) begin
         n.rearm = 1'b0;
      end
      // converter stays locked until clear or replug
      if (tdone[TM_OV2_IN] && !r.act.sys_ov) begin
         n.conv_lock = 1'b1;
      end else if (clr.sys_ov || adp_rise) begin
         n.conv_lock = 1'b0;
      end
      // sticky flags, a new event beats the clear
      n.flags = (r.flags & ~clr) | (n.act & ~r.act);

      // ========================================================
      // power path decisions
      dis_blk = r.act.port_ov || r.act.overload || r.act.short_c ||
                r.act.bat_uv || r.act.bat_ov || r.rearm;
      n.dis_on = r.dis_en && !dis_blk && !r.conv_lock && !r.act.sys_ov;
      n.chg_on = r.chg_en && !r.dis_en && !r.act.in_ov &&
                 !r.act.chg_ov && !r.conv_lock && !r.act.sys_ov;
      n.conv_on = n.dis_on || n.chg_on;
      // switch off only at level two
      n.fet_off = r.act.sys_ov;
      dr_act = r.act.chg_ov || r.act.sys_ov1;
      if (!dr_act || r.dcnt == TW'(P_64MS - 1)) begin
         n.dcnt = '0;
      end else begin
         n.dcnt = r.dcnt + 1'b1;
      end
      n.drain_on = dr_act && (r.dcnt < TW'(P_16MS));
      n.pwm_cut = r.conv_on && r.s2.peak_over;
      // charge current backs off at limit
      n.inl_red = r.chg_on && r.s2.in_limit;
      // pin low while any flag stands
      n.irq_oe = |n.flags;

      // ========================================================
      // comparator levels
      // output setting, 10mV steps, capped
      vset = LVL_VOUT_BASE + {1'b0, r.vout};
      if (vset > LVL_VOUT_MAX) begin
         vset = LVL_VOUT_MAX;
      end
      n.lvl.pov = r.reg_mode ? pct(vset, PCT_112) : LVL_POV_FB;
      n.lvl.povx = r.reg_mode ? pct(vset, PCT_106) : LVL_POVX_FB;
      n.lvl.ovl = r.reg_mode ? pct(vset, PCT_80) : LVL_SHORT;
      n.lvl.shrt = LVL_SHORT;
      t12 = LVL_UV_BASE + 12'(r.uv) * LVL_STEP;
      if (t12 > LVL_UV_MAX) begin
         t12 = LVL_UV_MAX;
      end
      hl = LVL_HYS_BASE + 12'(r.hys) * LVL_STEP;
      if (hl > LVL_HYS_MAX) begin
         hl = LVL_HYS_MAX;
      end
      n.lvl.uv = t12;
      n.lvl.uvx = t12 + hl;
      n.lvl.bov = LVL_HI_OV;
      n.lvl.bovx = LVL_HI_OVX;
      n.lvl.iov = LVL_HI_OV;
      n.lvl.iovx = LVL_HI_OVX;
      n.lvl.cov = pct(r.chgt, PCT_104);
      n.lvl.covx = pct(r.chgt, PCT_102);
      n.lvl.ov1 = pct(r.sysmin, PCT_108);
      n.lvl.ov1x = n.lvl.ov1 - LVL_OV1_HYS;
      case (r.cells)
         2'h0: {n.lvl.ov2, n.lvl.ov2x} = {LVL_OV2_1S, LVL_OV2X_1S};
         2'h1: {n.lvl.ov2, n.lvl.ov2x} = {LVL_OV2_2S, LVL_OV2X_2S};
         default: {n.lvl.ov2, n.lvl.ov2x} = {LVL_OV2_34S, LVL_OV2X_34S};
      endcase
      t12 = LVL_INL_BASE + 12'(r.inl) * LVL_STEP;
      n.lvl.inl = (t12 > LVL_INL_MAX) ? LVL_INL_MAX : t12;
   end

   // state register, frozen while ce is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.uv <= UV_RST;
         r.hys <= HYS_RST;
         r.chgt <= CHGT_RST;
         r.sysmin <= SYSMIN_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   // ===========================================================
   // outputs
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign dischg_on = r.dis_on;
   assign chg_on = r.chg_on;
   assign conv_on = r.conv_on;
   assign battery_path_switch_off = r.fet_off;
   assign drain_on = r.drain_on;
   assign pwm_cut = r.pwm_cut;
   assign in_limit_reduce = r.inl_red;
   assign peak_current_limit_setting = r.ilim;
   assign switch_resistance_setting = r.rdson;
   assign lvl = r.lvl;
   assign irq_o = 1'b0;
   assign irq_oe = r.irq_oe;

   // ===========================================================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   fet_level_two_a: assert property (ce && r.act.sys_ov |=> r.fet_off)
      else $error("switch not off at level two");
   uv_keeps_fet_a: assert property (ce && r.act.bat_uv && !r.act.sys_ov
                                    |=> !r.fet_off)
      else $error("switch off during undervoltage");
   rearm_blocks_a: assert property (ce && r.rearm |=> !r.dis_on)
      else $error("discharge on while latched");
   lock_holds_a: assert property (ce && r.conv_lock && !wr_clr_sov() &&
                                  !(r.s2.adapter && !r.adp_d)
                                  |=> r.conv_lock)
      else $error("converter lock released early");
   drain_window_a: assert property (r.drain_on
                                    |-> r.dcnt <= TW'(P_16MS))
      else $error("drain outside its window");
   ov1_fast_a: assert property (ce && r.s2.sys_ov1 && !r.act.sys_ov1
                                |=> r.act.sys_ov1)
      else $error("level one not immediate");
   fb_levels_a: assert property (ce && !r.reg_mode
                                 |=> r.lvl.pov == LVL_POV_FB &&
                                     r.lvl.povx == LVL_POVX_FB)
      else $error("divider mode levels wrong");
   peak_cut_a: assert property (ce && r.conv_on && r.s2.peak_over
                                |=> r.pwm_cut)
      else $error("on-phase not cut");
   // a fresh event must drive the pin even against a clear
   irq_follow_a: assert property (ce && |(n.act & ~r.act)
                                  |=> r.irq_oe)
      else $error("interrupt pin not low");
   cv_drain_c: cover property ($rose(r.drain_on));
   cv_lock_c: cover property ($rose(r.conv_lock));
   cv_short_c: cover property ($rose(r.flags.short_c));

   function automatic logic wr_clr_sov();
      return psel && penable && r.pready && pwrite &&
             paddr == REG_FLAGS && pwdata[0];
   endfunction
endmodule
`default_nettype wire

// ### hw/power_path_pkg.sv
package power_path_pkg;
   // ===========================================================
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_4MS_NS      = 4_000_000;
   localparam int T_16MS_NS     = 16_000_000;
   localparam int T_32MS_NS     = 32_000_000;
   localparam int T_36MS_NS     = 36_000_000;
   localparam int T_64MS_NS     = 64_000_000;
   localparam int T_100US_NS    = 100_000;
   localparam int T_30US_NS     = 30_000;
   // least times, rounded up to whole cycles
   localparam int CYC_4MS   = (T_4MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_16MS  = (T_16MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_32MS  = (T_32MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_36MS  = (T_36MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_64MS  = (T_64MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_100US = (T_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_30US  = (T_30US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TW        = 21;
   // ===========================================================
   // register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_VOUT   = 8'h04;
   localparam logic [7:0] REG_UV     = 8'h08;
   localparam logic [7:0] REG_INLIM  = 8'h0c;
   localparam logic [7:0] REG_CHGT   = 8'h10;
   localparam logic [7:0] REG_SYSMIN = 8'h14;
   localparam logic [7:0] REG_FLAGS  = 8'h18;
   localparam logic [7:0] REG_STATE  = 8'h1c;
   // reset values
   localparam logic [6:0]  UV_RST     = 7'h03;
   localparam logic [4:0]  HYS_RST    = 5'h00;
   localparam logic [11:0] CHGT_RST   = 12'h1a4;
   localparam logic [11:0] SYSMIN_RST = 12'h14a;
   // ===========================================================
   // levels in 10 mV units
   localparam logic [11:0] LVL_VOUT_BASE = 12'h12c;
   localparam logic [11:0] LVL_VOUT_MAX  = 12'h898;
   localparam logic [11:0] LVL_POV_FB    = 12'h960;
   localparam logic [11:0] LVL_POVX_FB   = 12'h8e2;
   localparam logic [11:0] LVL_SHORT     = 12'h0b0;
   localparam logic [11:0] LVL_UV_BASE   = 12'h10e;
   localparam logic [11:0] LVL_UV_MAX    = 12'h528;
   localparam logic [11:0] LVL_HYS_BASE  = 12'h028;
   localparam logic [11:0] LVL_HYS_MAX   = 12'h0c8;
   localparam logic [11:0] LVL_STEP      = 12'h00a;
   localparam logic [11:0] LVL_HI_OV     = 12'ha28;
   localparam logic [11:0] LVL_HI_OVX    = 12'h99f;
   localparam logic [11:0] LVL_INL_BASE  = 12'h190;
   localparam logic [11:0] LVL_INL_MAX   = 12'h7d0;
   localparam logic [11:0] LVL_OV1_HYS   = 12'h006;
   localparam logic [11:0] LVL_OV2_1S    = 12'h1f4;
   localparam logic [11:0] LVL_OV2X_1S   = 12'h1e0;
   localparam logic [11:0] LVL_OV2_2S    = 12'h4b0;
   localparam logic [11:0] LVL_OV2X_2S   = 12'h47e;
   localparam logic [11:0] LVL_OV2_34S   = 12'h79e;
   localparam logic [11:0] LVL_OV2X_34S  = 12'h76c;
   // percent factors
   localparam logic [6:0] PCT_112 = 7'h70;
   localparam logic [6:0] PCT_106 = 7'h6a;
   localparam logic [6:0] PCT_80  = 7'h50;
   localparam logic [6:0] PCT_104 = 7'h68;
   localparam logic [6:0] PCT_102 = 7'h66;
   localparam logic [6:0] PCT_108 = 7'h6c;
   // ===========================================================
   // timer slots
   localparam int NTMR = 14;
   localparam int TM_POV_IN = 0;
   localparam int TM_POV_OUT = 1;
   localparam int TM_OVL = 2;
   localparam int TM_SHT = 3;
   localparam int TM_UV_IN = 4;
   localparam int TM_UV_OUT = 5;
   localparam int TM_BOV_IN = 6;
   localparam int TM_BOV_OUT = 7;
   localparam int TM_IOV_IN = 8;
   localparam int TM_IOV_OUT = 9;
   localparam int TM_COV_IN = 10;
   localparam int TM_COV_OUT = 11;
   localparam int TM_OV2_IN = 12;
   localparam int TM_OV2_OUT = 13;
   // ===========================================================
   // types
   typedef struct packed {
      logic port_ov, port_ov_exit, port_ovl, port_short;
      logic bat_uv, bat_uv_exit, bat_ov, bat_ov_exit;
      logic in_ov, in_ov_exit, in_limit, chg_ov, chg_ov_exit;
      logic sys_ov1, sys_ov1_exit, sys_ov2, sys_ov2_exit;
      logic peak_over, adapter;
   } cmp_t;
   typedef struct packed {
      logic port_ov, overload, short_c, bat_uv, bat_ov;
      logic in_ov, chg_ov, sys_ov1, sys_ov;
   } flags_t;
   typedef struct packed {
      logic [11:0] pov, povx, ovl, shrt, uv, uvx, bov, bovx;
      logic [11:0] iov, iovx, cov, covx, ov1, ov1x, ov2, ov2x, inl;
   } lvl_t;
endpackage

// ### hw/qual_timer.sv
`timescale 1ns/100ps
`default_nettype none
module qual_timer
   import power_path_pkg::*;
(
   // clocking
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   // condition and limit
   input  wire logic          cond,
   input  wire logic [TW-1:0] limit,
   output logic               done
);
   typedef struct packed {
      logic [TW-1:0] cnt;
   } tst_t;
   tst_t r, n;
   always_comb begin
      n = r;
      if (!cond) begin
         n.cnt = '0;
      end else if (r.cnt != limit) begin
         n.cnt = r.cnt + 1'b1;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
   // held for the full limit
   assign done = cond && (r.cnt == limit);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   timer_restart_a: assert property (ce && !cond |=> r.cnt == '0)
      else $error("timer did not restart");
endmodule
`default_nettype wire

// ### testbench/power_path_model.sv
`timescale 1ns/100ps
`default_nettype none
module power_path_model
   import power_path_pkg::*;
(
   // levels and voltages, 10 mV units
   input  wire power_path_pkg::lvl_t lvl,
   input  wire logic [11:0]          v_port,
   input  wire logic [11:0]          v_bat,
   input  wire logic [11:0]          v_sys,
   input  wire logic                 peak,
   input  wire logic                 adapter,
   // comparator results
   output wire power_path_pkg::cmp_t cmp
);
   import power_path_pkg::*;
   // ideal comparators: no offset, so edges fall exactly on levels
   assign cmp = '{v_port > lvl.pov, v_port < lvl.povx, v_port < lvl.ovl,
      v_port < lvl.shrt, v_bat < lvl.uv, v_bat > lvl.uvx, v_bat > lvl.bov,
      v_bat < lvl.bovx, v_port > lvl.iov, v_port < lvl.iovx,
      v_port <= lvl.inl, v_bat > lvl.cov, v_bat < lvl.covx,
      v_sys > lvl.ov1, v_sys < lvl.ov1x, v_sys > lvl.ov2,
      v_sys < lvl.ov2x, peak, adapter};
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("unexpected %0t %h %h", $time, a, e); end end
module tb;
   import power_path_pkg::*;
   localparam int P16 = 40;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, dis, chg, conv, fet_off, drain, oe;
   logic ce = 1, pk = 0, adp = 0, cut, ilr, irq;
   logic [1:0] pls, rss;
   logic [11:0] vp = 12'h1f4, vb = 12'h4b0, vs = 12'h12c;
   cmp_t cmp;
   lvl_t lvl;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   typedef struct {logic [31:0] c, v; logic [11:0] pov, ovl, o2, o2x;} row_t;
   row_t rows [4] = '{'{0, 0, 12'h960, 12'h0b0, 12'h1f4, 12'h1e0},
      '{8, 0, 12'h960, 12'h0b0, 12'h4b0, 12'h47e},
      '{20, 700, 12'h460, 12'h320, 12'h79e, 12'h76c},
      '{28, 700, 12'h460, 12'h320, 12'h79e, 12'h76c}};
   // ===========================================================
   // clock, timeout
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done;
      end
   end
   power_path_model u_mdl (.lvl(lvl), .v_port(vp), .v_bat(vb), .v_sys(vs),
      .peak(pk), .adapter(adp), .cmp(cmp));
   fault_supervisor #(.P_4MS(20), .P_16MS(P16), .P_32MS(60), .P_36MS(70),
      .P_64MS(100)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_raw(cmp), .dischg_on(dis), .chg_on(chg),
      .conv_on(conv), .battery_path_switch_off(fet_off), .drain_on(drain),
      .pwm_cut(cut), .in_limit_reduce(ilr), .peak_current_limit_setting(pls),
      .switch_resistance_setting(rss), .lvl(lvl), .irq_o(irq), .irq_oe(oe));
   // apb cycle: hold request until pready sampled high
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
      @(posedge core_clk);
      penable <= 1;
      // ends on pready high; only the bench timeout ends a hung wait
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = pslverr ? 32'hdead_0000 : prdata;
      {psel, penable} <= 2'b00;
   endtask
   task wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task test_done;
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      wt(12);
      rst_n <= 1;
      apb(REG_UV, 0, 0);
      `CHK(rd, 32'h3)
      apb(REG_CHGT, 0, 0);
      `CHK(rd, 32'h1a4)
      `CHK({lvl.uv, lvl.uvx}, {12'h12c, 12'h154})
      apb(8'h20, 0, 0);
      `CHK(rd, 32'hdead_0000)
      // level tables per mode and cell count
      foreach (rows[i]) begin
         apb(REG_VOUT, 1, rows[i].v);
         apb(REG_CTRL, 1, rows[i].c);
         wt(3);
         `CHK({lvl.pov, lvl.ovl}, {rows[i].pov, rows[i].ovl})
         `CHK({lvl.ov2, lvl.ov2x}, {rows[i].o2, rows[i].o2x})
      end
      apb(REG_CTRL, 1, 1);
      wt(10);
      `CHK(dis, 1'b1)
      // broken overvoltage must restart its timer
      vp <= 12'h9c4;
      wt(20);
      vp <= 12'h1f4;
      wt(10);
      vp <= 12'h9c4;
      wt(P16 - 5);
      `CHK(dis, 1'b1)
      wt(15);
      `CHK({dis, oe}, 2'b01)
      vp <= 12'h1f4;
      wt(P16 + 10);
      `CHK(dis, 1'b1)
      // short latches until clear and re-enable
      vp <= 12'h064;
      wt(30);
      `CHK(dis, 1'b0)
      vp <= 12'h1f4;
      apb(REG_FLAGS, 1, 32'h1ff);
      wt(5);
      `CHK({dis, oe}, 2'b00)
      apb(REG_CTRL, 1, 0);
      apb(REG_CTRL, 1, 1);
      wt(10);
      `CHK({dis, conv}, 2'b11)
      // rail level one then level two
      vs <= 12'h258;
      wt(10);
      `CHK(drain, 1'b1)
      wt(770);
      `CHK({conv, fet_off}, 2'b01)
      vs <= 12'h12c;
      wt(30);
      `CHK({conv, fet_off}, 2'b00)
      apb(REG_FLAGS, 1, 32'h1);
      wt(10);
      `CHK(conv, 1'b1)
      // limit fields, on-phase cut, frozen while ce is low
      apb(REG_CTRL, 1, 32'h1e1);
      wt(2);
      `CHK({pls, rss, irq}, 5'h1e)
      ce <= 0;
      pk <= 1;
      wt(6);
      `CHK(cut, 1'b0)
      ce <= 1;
      wt(4);
      `CHK(cut, 1'b1)
      pk <= 0;
      // battery undervoltage keeps the switch on
      vb <= 12'h0c8;
      wt(66);
      `CHK({dis, fet_off}, 2'b00)
      vb <= 12'h4b0;
      wt(106);
      `CHK(dis, 1'b1)
      // charge mode: replug releases lock, input limit, drain
      apb(REG_CHGT, 1, 32'h4b0);
      apb(REG_CTRL, 1, 32'h2);
      vs <= 12'h258;
      wt(780);
      vs <= 12'h12c;
      wt(30);
      `CHK({chg, conv}, 2'b00)
      adp <= 1;
      wt(6);
      `CHK({chg, conv}, 2'b11)
      vp <= 12'h190;
      wt(4);
      `CHK(ilr, 1'b1)
      vp <= 12'h1f4;
      vb <= 12'h4e2;
      wt(P16 + 6);
      `CHK({chg, drain}, 2'b01)
      vb <= 12'h4b0;
      wt(P16 + 6);
      `CHK({chg, drain}, 2'b10)
      // second reset in mid-run
      rst_n <= 0;
      wt(2);
      rst_n <= 1;
      wt(2);
      `CHK({chg, conv, drain, oe}, 4'h0)
      apb(REG_UV, 0, 0);
      `CHK(rd, 32'h3)
      test_done;
   end
endmodule
`default_nettype wire
